/* File: rtl/pin_change_pkg.sv */
// Function
// - Pin change request only while master enable set
// - Flags keep setting with master enable clear
// - Per-pin rising detector armed by rise enable
// - Per-pin falling detector armed by fall enable
// - Both enables set flag either direction
// - Detected edge sets flag, requests if enabled
// - Flag set on enabled rise or fall
// - Summary flag is OR of all pin flags
// - Writing zero clears flag, one never sets
// - Edge during flag write leaves flag set
// - Enabled pin change wakes from sleep
// - Sleep edges land in flags in the same cycle as wake
// - First port implements bits 5-3, 1-0 only
// - First port pins 0-1 need serial bus off
// - Enables and flags reset to zero
// - Second port implements bits 7-4 only
package pin_change_pkg;

  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] FIRST_PORT_RISE_OFFSET = 8'h04;
  localparam logic [7:0] FIRST_PORT_FALL_OFFSET = 8'h08;
  localparam logic [7:0] FIRST_PORT_FLAGS_OFFSET = 8'h0c;
  localparam logic [7:0] SECOND_PORT_RISE_OFFSET = 8'h10;
  localparam logic [7:0] SECOND_PORT_FALL_OFFSET = 8'h14;
  localparam logic [7:0] SECOND_PORT_FLAGS_OFFSET = 8'h18;
  localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h1c;
  localparam logic [7:0] IRQ_MASK_OFFSET = 8'h20;

  // Fields of interrupt_control_reg
  localparam int SUMMARY_FLAG_BIT = 0;
  localparam int MASTER_ENABLE_BIT = 1;
  localparam int SERIAL_BUS_ENABLE_BIT = 2;

  // Fields of the irq status and mask registers
  localparam int EDGE_EVENT_BIT = 0;
  localparam int WAKE_EVENT_BIT = 1;

  localparam logic [7:0] FIRST_PORT_IMPL_MASK = 8'h3b;
  localparam logic [7:0] SECOND_PORT_IMPL_MASK = 8'hf0;
  // First port pins that share their input buffer with the serial bus
  localparam logic [7:0] FIRST_PORT_SHARED_MASK = 8'h03;

  localparam logic [7:0] EDGE_RESET = 8'h00;
  localparam logic [1:0] IRQ_RESET = 2'h0;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } wb_rsp_t;

  typedef struct packed {
    logic [7:0] rise;
    logic [7:0] fall;
    logic [7:0] flags;
  } port_cfg_t;

endpackage

/* File: rtl/pin_change_interrupt.sv */
`timescale 1ns/10ps
module pin_change_interrupt (
  input wire logic clk,
  input wire logic srst,
  input wire pin_change_pkg::wb_req_t wb_req,
  output pin_change_pkg::wb_rsp_t wb_rsp,
  input wire logic [7:0] first_port,
  input wire logic [7:0] second_port,
  input wire logic sleep_active,
  output logic pin_change_irq,
  output logic wake,
  output logic irq
);

  typedef struct packed {
    logic [15:0] sync1;
    logic [15:0] sync2;
    logic [15:0] sync3;
    logic [15:0] level;
    pin_change_pkg::port_cfg_t port_a;
    pin_change_pkg::port_cfg_t port_b;
    logic master_en;
    logic bus_en;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    pin_change_pkg::wb_rsp_t rsp;
    logic pc_req;
    logic wake;
    logic irq;
  } state_t;

  state_t s;
  state_t next_s;

  logic [15:0] rise_seen;
  logic [15:0] fall_seen;
  logic [15:0] rise_en;
  logic [15:0] fall_en;
  logic [15:0] live_mask;
  logic [15:0] hit;

  assign rise_en = {s.port_b.rise, s.port_a.rise};
  assign fall_en = {s.port_b.fall, s.port_a.fall};
  // Shared pins see nothing while the serial bus owns their input buffers
  assign live_mask = {pin_change_pkg::SECOND_PORT_IMPL_MASK,
                      pin_change_pkg::FIRST_PORT_IMPL_MASK &
                      ~(s.bus_en ? pin_change_pkg::FIRST_PORT_SHARED_MASK : 8'h00)};

  genvar i;
  generate
    for (i = 0; i < 16; i++) begin : g_pin
      // A change counts once stages two and three agree on the new level
      assign rise_seen[i] = (s.sync2[i] == s.sync3[i]) & s.sync3[i] & ~s.level[i];
      assign fall_seen[i] = (s.sync2[i] == s.sync3[i]) & ~s.sync3[i] & s.level[i];
      assign hit[i] = live_mask[i] &
                      ((rise_seen[i] & rise_en[i]) |
                       (fall_seen[i] & fall_en[i]));
    end
  endgenerate

  logic access;
  logic wr;
  logic [31:0] rd;
  logic [7:0] wbyte;
  logic any_flag;

  always_comb begin
    next_s = s;
    access = wb_req.cyc & wb_req.stb & ~s.rsp.ack;
    wr = access & wb_req.we & wb_req.sel[0];
    wbyte = wb_req.dat[7:0];
    next_s.sync1 = {second_port, first_port};
    next_s.sync2 = s.sync1;
    next_s.sync3 = s.sync2;
    for (int k = 0; k < 16; k++) begin
      if (s.sync2[k] == s.sync3[k]) begin
        next_s.level[k] = s.sync3[k];
      end
    end

    if (wr && wb_req.adr == pin_change_pkg::CTRL_OFFSET) begin
      next_s.master_en = wbyte[pin_change_pkg::MASTER_ENABLE_BIT];
      next_s.bus_en = wbyte[pin_change_pkg::SERIAL_BUS_ENABLE_BIT];
    end
    if (wr && wb_req.adr == pin_change_pkg::FIRST_PORT_RISE_OFFSET) begin
      next_s.port_a.rise = wbyte & pin_change_pkg::FIRST_PORT_IMPL_MASK;
    end
    if (wr && wb_req.adr == pin_change_pkg::FIRST_PORT_FALL_OFFSET) begin
      next_s.port_a.fall = wbyte & pin_change_pkg::FIRST_PORT_IMPL_MASK;
    end
    if (wr && wb_req.adr == pin_change_pkg::SECOND_PORT_RISE_OFFSET) begin
      next_s.port_b.rise = wbyte & pin_change_pkg::SECOND_PORT_IMPL_MASK;
    end
    if (wr && wb_req.adr == pin_change_pkg::SECOND_PORT_FALL_OFFSET) begin
      next_s.port_b.fall = wbyte & pin_change_pkg::SECOND_PORT_IMPL_MASK;
    end

    // A write can only clear flags; a fresh edge wins over the clear
    if (wr && wb_req.adr == pin_change_pkg::FIRST_PORT_FLAGS_OFFSET) begin
      next_s.port_a.flags = s.port_a.flags & wbyte;
    end
    if (wr && wb_req.adr == pin_change_pkg::SECOND_PORT_FLAGS_OFFSET) begin
      next_s.port_b.flags = s.port_b.flags & wbyte;
    end
    // Flags track edges regardless of master enable or sleep
    next_s.port_a.flags = (next_s.port_a.flags | hit[7:0]) &
                          pin_change_pkg::FIRST_PORT_IMPL_MASK;
    next_s.port_b.flags = (next_s.port_b.flags | hit[15:8]) &
                          pin_change_pkg::SECOND_PORT_IMPL_MASK;

    any_flag = |{next_s.port_a.flags, next_s.port_b.flags};
    next_s.pc_req = s.master_en & any_flag;
    next_s.wake = sleep_active & s.master_en & (|hit);

    if (wr && wb_req.adr == pin_change_pkg::IRQ_STATUS_OFFSET) begin
      next_s.irq_status = s.irq_status & ~wbyte[1:0];
    end
    if (wr && wb_req.adr == pin_change_pkg::IRQ_MASK_OFFSET) begin
      next_s.irq_mask = wbyte[1:0];
    end
    next_s.irq_status[pin_change_pkg::EDGE_EVENT_BIT] =
      next_s.irq_status[pin_change_pkg::EDGE_EVENT_BIT] | (|hit);
    next_s.irq_status[pin_change_pkg::WAKE_EVENT_BIT] =
      next_s.irq_status[pin_change_pkg::WAKE_EVENT_BIT] | next_s.wake;
    next_s.irq = |(next_s.irq_status & next_s.irq_mask);

    rd = 32'h0000_0000;
    case (wb_req.adr)
      pin_change_pkg::CTRL_OFFSET: begin
        rd[pin_change_pkg::SUMMARY_FLAG_BIT] = |{s.port_a.flags, s.port_b.flags};
        rd[pin_change_pkg::MASTER_ENABLE_BIT] = s.master_en;
        rd[pin_change_pkg::SERIAL_BUS_ENABLE_BIT] = s.bus_en;
      end
      pin_change_pkg::FIRST_PORT_RISE_OFFSET: rd[7:0] = s.port_a.rise;
      pin_change_pkg::FIRST_PORT_FALL_OFFSET: rd[7:0] = s.port_a.fall;
      pin_change_pkg::FIRST_PORT_FLAGS_OFFSET: rd[7:0] = s.port_a.flags;
      pin_change_pkg::SECOND_PORT_RISE_OFFSET: rd[7:0] = s.port_b.rise;
      pin_change_pkg::SECOND_PORT_FALL_OFFSET: rd[7:0] = s.port_b.fall;
      pin_change_pkg::SECOND_PORT_FLAGS_OFFSET: rd[7:0] = s.port_b.flags;
      pin_change_pkg::IRQ_STATUS_OFFSET: rd[1:0] = s.irq_status;
      pin_change_pkg::IRQ_MASK_OFFSET: rd[1:0] = s.irq_mask;
      default: rd = 32'h0000_0000;
    endcase
    // Unmapped addresses still ack so the master never hangs
    next_s.rsp.ack = access;
    next_s.rsp.dat = access ? rd : 32'h0000_0000;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign wb_rsp = s.rsp;
  assign pin_change_irq = s.pc_req;
  assign wake = s.wake;
  assign irq = s.irq;

endmodule

/* File: tb/pin_change_interrupt_sva.sv */
`timescale 1ns/10ps
module pin_change_interrupt_sva (
  input wire logic clk,
  input wire logic srst,
  input wire pin_change_pkg::wb_req_t wb_req,
  input wire pin_change_pkg::wb_rsp_t wb_rsp,
  input wire logic [7:0] first_port,
  input wire logic [7:0] second_port,
  input wire logic sleep_active,
  input wire logic pin_change_irq,
  input wire logic wake,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  ack_pulse_a: assert property (wb_rsp.ack |=> !wb_rsp.ack)
    else $error("ack too long");
  ack_delay_a: assert property ($rose(wb_req.stb) |=> wb_rsp.ack)
    else $error("ack late");
  first_port_unused_a: assert property (wb_rsp.ack && wb_req.adr inside {[8'h04:8'h0c]}
    |-> (wb_rsp.dat[7:0] & ~pin_change_pkg::FIRST_PORT_IMPL_MASK) == 8'h00) else $error("first_port bits");
  second_port_unused_a: assert property (wb_rsp.ack && wb_req.adr inside {[8'h10:8'h18]}
    |-> wb_rsp.dat[3:0] == 4'h0) else $error("second_port bits");
  irq_drop_a: assert property ($fell(pin_change_irq) |-> wb_rsp.ack || $past(wb_rsp.ack))
    else $error("irq fell alone");
  wake_enable_a: assert property (wake |-> pin_change_irq)
    else $error("wake without enable");
  wake_sleep_a: assert property (wake |-> $past(sleep_active))
    else $error("wake while awake");
  wake_pulse_a: assert property (wake |=> !wake)
    else $error("wake too long");
endmodule
bind pin_change_interrupt pin_change_interrupt_sva chk (.clk, .srst, .wb_req, .wb_rsp,
  .first_port, .second_port, .sleep_active, .pin_change_irq, .wake, .irq);

/* File: tb/pin_drive.sv */
`timescale 1ns/10ps
module pin_drive (
  input wire logic [15:0] want,
  output logic [7:0] first_port,
  output logic [7:0] second_port
);
  initial {second_port, first_port} = 16'h0000;
  // Pins move off the clock edge, as real ones do
  always @(want) #3 {second_port, first_port} = want;
endmodule

/* File: tb/test_pin_change_interrupt.sv */
`timescale 1ns/10ps
module test_pin_change_interrupt;
  logic clk = 0, srst = 1, sleep_active = 0, wake, irq, pc_irq;
  pin_change_pkg::wb_req_t req = '0;
  pin_change_pkg::wb_rsp_t rsp;
  logic [15:0] want = 16'h0000;
  logic [7:0] fp, sp, lv, nl;
  logic [7:0] expq[$];
  int failures = 0, cmp_count = 0, cycles = 0, wakes = 0, seed = 24815;
  always #4 clk = ~clk;
  pin_drive drv (.want(want), .first_port(fp), .second_port(sp));
  pin_change_interrupt uut (.clk(clk), .srst(srst), .wb_req(req), .wb_rsp(rsp),
    .first_port(fp), .second_port(sp), .sleep_active(sleep_active),
    .pin_change_irq(pc_irq), .wake(wake), .irq(irq));
  task automatic check(input string what, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out;
    if (failures == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, d, e);
    if (!w) expq.push_back(e);
    @(posedge clk);
    req <= '{1'b1, 1'b1, w, a, 4'hf, {24'h0, d}};
    do @(posedge clk); while (rsp.ack !== 1'b1);
    req <= '0;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (wake === 1'b1) wakes++;
    if (rsp.ack === 1'b1 && !req.we) check("read", rsp.dat, {24'h0, expq.pop_front()});
    if (cycles == 2000) begin
      failures++;
      close_out;
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    for (int a = 0; a <= 36; a += 4) bus(0, a[7:0], 8'h00, 8'h00);
    bus(1, 8'h24, 8'hff, 8'h00);
    for (int a = 4; a <= 24; a += 4) begin
      bus(1, a[7:0], 8'hff, 8'h00);
      bus(0, a[7:0], 8'h00, a % 12 == 0 ? 8'h00 : a < 12 ? 8'h3b : 8'hf0);
    end
    want <= 16'h0008;
    repeat (8) @(posedge clk);
    // Look between edges so the value is settled, not racing the flop
    @(negedge clk);
    check("pc irq", pc_irq, 0);
    bus(0, 8'h0c, 8'h00, 8'h08);
    bus(0, 8'h00, 8'h00, 8'h01);
    bus(1, 8'h00, 8'h02, 8'h00);
    repeat (2) @(posedge clk);
    @(negedge clk);
    check("pc irq", pc_irq, 1);
    bus(1, 8'h0c, 8'hf7, 8'h00);
    repeat (2) @(posedge clk);
    @(negedge clk);
    check("pc irq", pc_irq, 0);
    want <= 16'h0000;
    repeat (8) @(posedge clk);
    bus(0, 8'h0c, 8'h00, 8'h08);
    lv = 8'h00;
    repeat (4) begin
      nl = $random(seed) & 8'h3b;
      bus(1, 8'h0c, 8'h00, 8'h00);
      want <= {8'h00, nl};
      repeat (8) @(posedge clk);
      bus(0, 8'h0c, 8'h00, lv ^ nl);
      lv = nl;
    end
    bus(1, 8'h0c, 8'h00, 8'h00);
    bus(1, 8'h00, 8'h06, 8'h00);
    want <= {8'h00, lv ^ 8'h03};
    repeat (8) @(posedge clk);
    bus(0, 8'h0c, 8'h00, 8'h00);
    sleep_active <= 1'b1;
    want <= {8'h80, lv ^ 8'h03};
    repeat (8) @(posedge clk);
    @(negedge clk);
    check("wakes", wakes, 1);
    sleep_active <= 1'b0;
    bus(0, 8'h18, 8'h00, 8'h80);
    @(negedge clk);
    check("irq", irq, 0);
    bus(1, 8'h20, 8'h01, 8'h00);
    repeat (2) @(posedge clk);
    @(negedge clk);
    check("irq", irq, 1);
    bus(1, 8'h1c, 8'h03, 8'h00);
    repeat (2) @(posedge clk);
    @(negedge clk);
    check("irq", irq, 0);
    close_out;
  end
endmodule
